// file: rtl/adcsr_defs.vh
`ifndef ADCSR_DEFS_VH
`define ADCSR_DEFS_VH
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ADCSR_CLK_NS 25
`define ADCSR_T_CONV_NS 2200
`define ADCSR_CONV_CYC (`ADCSR_T_CONV_NS / `ADCSR_CLK_NS)
`define ADCSR_T_SCK_DLY_NS 270
`define ADCSR_SCK_DLY_CYC ((`ADCSR_T_SCK_DLY_NS + `ADCSR_CLK_NS - 1) / `ADCSR_CLK_NS)
`define ADCSR_T_SCK_PER_NS 110
`define ADCSR_SCK_PER_CYC (`ADCSR_T_SCK_PER_NS / `ADCSR_CLK_NS)
`define ADCSR_SCK_HALF_CYC (`ADCSR_SCK_PER_CYC / 2)
// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define ADCSR_RES_W 16
`define ADCSR_BITS 16
`define ADCSR_FIFO_DEPTH 32
`define ADCSR_FIFO_AW 5
`define ADCSR_RESULT_RST 16'h0000
`endif

// file: rtl/adcsr_fifo.v
`timescale 1ns/100ps
`default_nettype none
module adcsr_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_reg];
  always @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_next;
      in_ready <= (cnt_next != DEPTH[AW:0]);
    end
  end
endmodule // adcsr_fifo
`default_nettype wire

// file: rtl/adcsr_top.v
`timescale 1ns/100ps
`default_nettype none
`include "adcsr_defs.vh"
module adcsr_top (
  input wire sys_clk,
  input wire resetn,
  input wire cs_n,
  input wire read_convert,
  input wire power_down_in,
  input wire format_select,
  input wire clock_source_select,
  input wire shift_clock_in,
  input wire tag_in,
  input wire sample_valid,
  input wire [15:0] sample_data,
  output wire sample_ready,
  output reg busy_n,
  output reg shift_clock_out,
  output reg shift_clock_oe,
  output reg data_out,
  output reg sync_out
);
  // ----------------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------------
  localparam NS = 7;
  localparam CONV_CYC = `ADCSR_CONV_CYC;
  localparam SCK_DLY = `ADCSR_SCK_DLY_CYC - 1;
  localparam NBITS = `ADCSR_BITS;
  localparam PH_FALL = 1 + `ADCSR_SCK_HALF_CYC;
  reg [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  reg [NS-1:0] meta_reg;
  reg [NS-1:0] sync_reg;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 7'h03;
      sync_reg <= 7'h03;
    end else begin
      meta_reg <= {shift_clock_in, tag_in, clock_source_select, format_select,
                   power_down_in, read_convert, cs_n};
      sync_reg <= meta_reg;
    end
  end
  wire cs_s = sync_reg[0];
  wire rc_s = sync_reg[1];
  wire pd_s = sync_reg[2];
  wire fmt_s = sync_reg[3];
  wire ext_s = sync_reg[4];
  wire tag_s = sync_reg[5];
  wire sck_s = sync_reg[6];

  // ----------------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------------
  reg sel_prev_reg;
  reg cs_prev_reg;
  reg rc_prev_reg;
  reg sck_prev_reg;
  wire sel_n = cs_s | rc_s;
  wire conv_go = sel_prev_reg & ~sel_n & ~pd_s & busy_n;
  wire rd_go = ext_s & ((rc_s & ~rc_prev_reg & ~cs_s) | (~cs_s & cs_prev_reg & rc_s));
  wire sck_rise = sck_s & ~sck_prev_reg;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
      rc_prev_reg <= 1'b1;
      sck_prev_reg <= 1'b0;
    end else begin
      sel_prev_reg <= sel_n;
      cs_prev_reg <= cs_s;
      rc_prev_reg <= rc_s;
      sck_prev_reg <= sck_s;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion timing and result store
  // ----------------------------------------------------------------------
  reg [6:0] conv_cnt_reg;
  reg [15:0] result_reg;
  wire conv_done = ~busy_n & (conv_cnt_reg == 7'd1);
  wire fifo_valid;
  wire [15:0] fifo_data;
  wire [15:0] fmt_data = {fifo_data[15] ^ ~fmt_s, fifo_data[14:0]};

  adcsr_fifo #(
    .WIDTH(`ADCSR_RES_W),
    .DEPTH(`ADCSR_FIFO_DEPTH),
    .AW(`ADCSR_FIFO_AW)
  ) u_fifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out_valid(fifo_valid),
    .out_ready(conv_done),
    .out_data(fifo_data)
  );

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_n <= 1'b1;
      conv_cnt_reg <= 7'h00;
      result_reg <= `ADCSR_RESULT_RST;
    end else begin
      if (conv_go) begin
        busy_n <= 1'b0;
        conv_cnt_reg <= CONV_CYC[6:0];
      end else if (conv_done) begin
        busy_n <= 1'b1;
        conv_cnt_reg <= 7'h00;
        if (fifo_valid) begin
          result_reg <= fmt_data;
        end
      end else if (~busy_n) begin
        conv_cnt_reg <= conv_cnt_reg - 7'd1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Serial output: internal and external shift clock
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_SHIFT = 3'b100;
  reg [2:0] st_reg;
  reg [3:0] tmr_reg;
  reg [1:0] ph_reg;
  reg [4:0] bit_reg;
  reg [15:0] sr_reg;
  reg tag_hold_reg;
  reg rd_act_reg;
  reg ext_seen_reg;
  reg sync_pend_reg;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_IDLE;
      tmr_reg <= 4'h0;
      ph_reg <= 2'h0;
      bit_reg <= 5'h00;
      sr_reg <= 16'h0000;
      tag_hold_reg <= 1'b0;
      rd_act_reg <= 1'b0;
      ext_seen_reg <= 1'b0;
      sync_pend_reg <= 1'b0;
      shift_clock_out <= 1'b0;
      shift_clock_oe <= 1'b0;
      data_out <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      shift_clock_oe <= ~ext_s;
      if (ext_s) begin
        st_reg <= ST_IDLE;
        shift_clock_out <= 1'b0;
        if (rd_go) begin
          rd_act_reg <= 1'b1;
          sr_reg <= result_reg;
          sync_pend_reg <= ext_seen_reg | sck_rise;
          ext_seen_reg <= 1'b0;
          sync_out <= 1'b0;
        end else if (rd_act_reg) begin
          if (cs_s | ~rc_s) begin
            rd_act_reg <= 1'b0;
            sync_out <= 1'b0;
          end else if (sck_rise) begin
            if (sync_pend_reg) begin
              sync_out <= 1'b1;
              sync_pend_reg <= 1'b0;
            end else begin
              sync_out <= 1'b0;
              data_out <= sr_reg[15];
              sr_reg <= {sr_reg[14:0], tag_s};
            end
          end
        end else if (sck_rise) begin
          ext_seen_reg <= 1'b1;
          sync_out <= 1'b0;
        end
      end else begin
        rd_act_reg <= 1'b0;
        sync_out <= 1'b0;
        ext_seen_reg <= 1'b0;
        case (st_reg)
          ST_IDLE: begin
            shift_clock_out <= 1'b0;
            if (conv_go) begin
              st_reg <= ST_WAIT;
              tmr_reg <= SCK_DLY[3:0];
              sr_reg <= result_reg;
              tag_hold_reg <= tag_s;
            end
          end
          ST_WAIT: begin
            if (tmr_reg == 4'h0) begin
              st_reg <= ST_SHIFT;
              ph_reg <= 2'h0;
              bit_reg <= NBITS[4:0];
            end else begin
              tmr_reg <= tmr_reg - 4'h1;
            end
          end
          ST_SHIFT: begin
            ph_reg <= ph_reg + 2'h1;
            if (ph_reg == 2'h0) begin
              if (bit_reg == 5'h00) begin
                st_reg <= ST_IDLE;
                data_out <= tag_hold_reg;
              end else begin
                data_out <= sr_reg[15];
                sr_reg <= {sr_reg[14:0], 1'b0};
                bit_reg <= bit_reg - 5'h01;
              end
            end else if (ph_reg == 2'h1) begin
              shift_clock_out <= 1'b1;
            end else if (ph_reg == PH_FALL[1:0]) begin
              shift_clock_out <= 1'b0;
            end
          end
          default: begin
            st_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // adcsr_top
`default_nettype wire

// file: tb/adcsr_checker.sv
`timescale 1ns/100ps
`default_nettype none
module adcsr_checker (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic read_convert,
  input wire logic power_down_in,
  input wire logic clock_source_select,
  input wire logic busy_n,
  input wire logic shift_clock_out,
  input wire logic data_out,
  input wire logic sync_out
);
  logic [7:0] bcnt_reg;
  logic [4:0] pcnt_reg;
  logic sck_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Busy low time and clock pulses seen inside one conversion
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bcnt_reg <= 8'h00;
      pcnt_reg <= 5'h00;
      sck_reg <= 1'b0;
    end else begin
      bcnt_reg <= busy_n ? 8'h00 : bcnt_reg + 8'h01;
      pcnt_reg <= busy_n ? 5'h00 : pcnt_reg + {4'h0, shift_clock_out & ~sck_reg};
      sck_reg <= shift_clock_out;
    end
  end
  a_busy_len: assert property ($rose(busy_n) |-> bcnt_reg == 8'h58) else $error("busy");
  a_clk_idle: assert property (busy_n |-> !shift_clock_out) else $error("idle clk");
  a_clk_high: assert property ($rose(shift_clock_out) |-> ##1 shift_clock_out ##1
    !shift_clock_out) else $error("clk phase");
  a_pulse_cnt: assert property ($rose(busy_n) && !clock_source_select |->
    pcnt_reg == 5'h10) else $error("pulses");
  a_clk_delay: assert property ($fell(busy_n) && !clock_source_select |->
    !shift_clock_out [*8] ##6 $rose(shift_clock_out)) else $error("clk delay");
  a_sync_ext: assert property (sync_out |-> clock_source_select) else $error("sync");
  a_data_hold: assert property (shift_clock_out |-> $stable(data_out)) else $error("data");
  a_pd_block: assert property ($fell(busy_n) |-> !$past(power_down_in, 3)) else $error("pd");
  a_start_cause: assert property ($fell(busy_n) |-> !$past(cs_n, 3) &&
    !$past(read_convert, 3)) else $error("start");
  cover property ($rose(busy_n) && pcnt_reg == 5'h10);
  cover property ($rose(sync_out));
  cover property ($fell(cs_n) && read_convert);
endmodule // adcsr_checker
bind adcsr_top adcsr_checker chk_u (.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n),
  .read_convert(read_convert), .power_down_in(power_down_in), .busy_n(busy_n),
  .clock_source_select(clock_source_select), .shift_clock_out(shift_clock_out),
  .data_out(data_out), .sync_out(sync_out));
`default_nettype wire

// file: tb/adcsr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module adcsr_host_model #(
  parameter HALF_NS = 100,
  parameter SKEW_NS = 5
) (
  input wire logic go,
  input wire logic [4:0] n_pulses,
  input wire logic sdata,
  output logic sck,
  output logic [17:0] rx
);
  initial sck = 1'b0;
  initial rx = 18'h00000;
  // Clock runs only inside a burst and rests low between bursts
  always @(posedge go) begin
    // Skew keeps the link clock edges off the system clock edges
    #SKEW_NS;
    repeat (n_pulses) begin
      #HALF_NS sck = 1'b1;
      #HALF_NS sck = 1'b0;
      rx = {rx[16:0], sdata};
    end
  end
endmodule // adcsr_host_model
`default_nettype wire

// file: tb/adc_serial_readout_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module adc_serial_readout_tb_top;
  logic sys_clk = 1'b0;
  logic resetn, cs_n, read_convert, power_down_in, format_select, clock_source_select;
  logic tag_in, sample_valid, go, sync_seen, sck_q, b;
  logic [4:0] n_pulses;
  logic [15:0] sample_data, cap, c, v;
  logic [15:0] exp_q [0:31];
  wire busy_n, shift_clock_out, shift_clock_oe, data_out, sync_out, sample_ready, host_sck;
  wire [17:0] rx;
  wire sck_wire = shift_clock_oe ? shift_clock_out : host_sck;
  integer failures = 0, n_tests = 0, k, i;
  always #12.5 sys_clk = ~sys_clk;
  adcsr_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n),
    .read_convert(read_convert), .power_down_in(power_down_in),
    .format_select(format_select), .clock_source_select(clock_source_select),
    .shift_clock_in(sck_wire), .tag_in(tag_in), .sample_valid(sample_valid),
    .sample_data(sample_data), .sample_ready(sample_ready), .busy_n(busy_n),
    .shift_clock_out(shift_clock_out), .shift_clock_oe(shift_clock_oe),
    .data_out(data_out), .sync_out(sync_out));
  adcsr_host_model host_u (.go(go), .n_pulses(n_pulses), .sdata(data_out),
    .sck(host_sck), .rx(rx));
  always @(negedge sys_clk) begin
    if (shift_clock_out && !sck_q) cap <= {cap[14:0], data_out};
    if (sync_out) sync_seen <= 1'b1;
    sck_q <= shift_clock_out;
  end
  task tally_and_finish;
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] want);
    n_tests = n_tests + 1;
    if (got !== want) begin
      failures = failures + 1;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wait_busy(input logic lvl);
    for (i = 0; i < 200 && busy_n !== lvl; i = i + 1) @(negedge sys_clk);
    if (busy_n !== lvl) begin
      failures = failures + 1;
      tally_and_finish;
    end
  endtask
  task conv(output logic [15:0] res);
    @(posedge sys_clk);
    read_convert <= 1'b0;
    wait_busy(1'b0);
    wait_busy(1'b1);
    res = cap;
    @(posedge sys_clk);
    read_convert <= 1'b1;
    tick(60);
  endtask
  task fill_and_drain;
    for (k = 0; k < 32; k = k + 1) begin
      @(posedge sys_clk);
      v = 16'ha5c3 + k[15:0] * 16'h0731;
      sample_valid <= 1'b1;
      sample_data <= v;
      exp_q[k] = v ^ {~k[0], 15'h0000};
      @(negedge sys_clk);
      for (i = 0; i < 20 && sample_ready !== 1'b1; i = i + 1) @(negedge sys_clk);
      if (sample_ready !== 1'b1) begin
        failures = failures + 1;
        tally_and_finish;
      end
      @(posedge sys_clk);
      sample_valid <= 1'b0;
    end
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    tick(3);
    @(negedge sys_clk);
    chk({15'h0000, sample_ready}, 16'h0000);
    chk({15'h0000, shift_clock_oe}, 16'h0001);
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    for (k = 0; k < 34; k = k + 1) begin
      @(posedge sys_clk);
      format_select <= k[0] | k[5];
      conv(c);
      if (k > 0) chk(c, exp_q[(k > 32) ? 31 : k - 1]);
    end
  endtask
  task power_down_hold;
    b = 1'b0;
    @(posedge sys_clk);
    power_down_in <= 1'b1;
    tick(4);
    read_convert <= 1'b0;
    repeat (40) @(negedge sys_clk) b = b | !busy_n;
    chk({15'h0000, b}, 16'h0000);
    @(posedge sys_clk);
    read_convert <= 1'b1;
    power_down_in <= 1'b0;
    tick(5);
    conv(c);
    chk(c, exp_q[31]);
  endtask
  task ext_read;
    @(posedge sys_clk);
    clock_source_select <= 1'b1;
    cs_n <= 1'b1;
    tag_in <= 1'b1;
    n_pulses <= 5'h01;
    tick(5);
    go <= 1'b1;
    tick(12);
    go <= 1'b0;
    cs_n <= 1'b0;
    n_pulses <= 5'h12;
    tick(6);
    go <= 1'b1;
    tick(152);
    chk(rx[16:1], exp_q[31]);
    chk({15'h0000, rx[0]}, 16'h0001);
    chk({15'h0000, sync_seen}, 16'h0001);
    cs_n <= 1'b1;
    go <= 1'b0;
  endtask
  task ext_read_nosync;
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    sample_data <= 16'h9e71;
    format_select <= 1'b0;
    read_convert <= 1'b0;
    sync_seen <= 1'b0;
    n_pulses <= 5'h11;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    tick(4);
    cs_n <= 1'b0;
    wait_busy(1'b0);
    wait_busy(1'b1);
    chk({15'h0000, busy_n}, 16'h0001);
    @(posedge sys_clk);
    read_convert <= 1'b1;
    tick(6);
    go <= 1'b1;
    tick(144);
    chk(rx[16:1], 16'h1e71);
    chk({15'h0000, rx[0]}, 16'h0001);
    chk({15'h0000, sync_seen}, 16'h0000);
    chk({15'h0000, shift_clock_oe}, 16'h0000);
    cs_n <= 1'b1;
    go <= 1'b0;
  endtask
  initial begin
    resetn = 1'b0;
    cs_n = 1'b0;
    read_convert = 1'b1;
    power_down_in = 1'b0;
    format_select = 1'b1;
    clock_source_select = 1'b0;
    tag_in = 1'b0;
    sample_valid = 1'b0;
    sample_data = 16'h0000;
    go = 1'b0;
    n_pulses = 5'h00;
    sync_seen = 1'b0;
    sck_q = 1'b0;
    cap = 16'h0000;
    tick(8);
    resetn <= 1'b1;
    tick(6);
    fill_and_drain;
    power_down_hold;
    ext_read;
    ext_read_nosync;
    tally_and_finish;
  end
endmodule // adc_serial_readout_tb_top
`default_nettype wire
